// File: rtl/rsq_pkg.sv
// constants and types for the rail sequencer
package rsq_pkg;
	localparam int unsigned CLK_HZ      = 250_000_000;
	localparam int unsigned SS_TIME_MS  = 5;
	localparam int unsigned POR_TIME_MS = 150;
	localparam int unsigned SS_CYCLES   = CLK_HZ / 1000 * SS_TIME_MS;
	localparam int unsigned POR_CYCLES  = CLK_HZ / 1000 * POR_TIME_MS;
	localparam int unsigned TEMP_WARN_C = 130;
	localparam int unsigned TEMP_SD_C   = 165;
	localparam int unsigned NUM_FANS    = 3;
	localparam int unsigned PWM_W       = 8;
	localparam int unsigned MCFG_W      = 16;
	localparam logic [PWM_W-1:0]  PWM_RST  = 8'h00;
	localparam logic [MCFG_W-1:0] MCFG_RST = 16'h0000;
	localparam int unsigned CNT_W = 32;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_CORE_SS,
		ST_MAIN_SS,
		ST_RUN
	} rsq_state_e;
endpackage

// File: rtl/rsq_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rsq_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: rtl/rsq_top.sv
// rail sequencing, supervision and masked system reset
`timescale 1ns/1ps
`default_nettype none
module rsq_top
	import rsq_pkg::*;
#(
	parameter int unsigned SS_CNT  = SS_CYCLES,
	parameter int unsigned POR_CNT = POR_CYCLES
) (
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	input  wire logic              INPUT_ABOVE_SHUTDOWN,
	input  wire logic              INPUT_ABOVE_WARN,
	input  wire logic              CORE_ABOVE_UVLO,
	input  wire logic              RAIL_3V3_ABOVE_UVLO,
	input  wire logic              RAIL_2V5_ABOVE_UVLO,
	input  wire logic              CHARGE_PUMP_OK,
	input  wire logic              INTERNAL_REG_OK,
	input  wire logic              TEMP_ABOVE_WARN,
	input  wire logic              TEMP_ABOVE_SHUTDOWN,
	input  wire logic              SYSTEM_RESET_N,
	input  wire logic              FAN_RESET_MASK,
	input  wire logic              REGULATOR_RESET_MASK,
	input  wire logic              MOTOR_CFG_RESET_MASK,
	input  wire logic              MOTOR_OUT_EN_RESET_MASK,
	input  wire logic              THERMAL_WARNING_IRQ_EN,
	input  wire logic              CFG_WR,
	input  wire logic              CFG_LIN_A_EN,
	input  wire logic              CFG_LIN_B_EN,
	input  wire logic              CFG_5V_EN,
	input  wire logic              CFG_MOTOR_RAIL_EN,
	input  wire logic [NUM_FANS-1:0] CFG_FAN_EN,
	input  wire logic [PWM_W-1:0]  CFG_FAN_PWM,
	input  wire logic [1:0]        CFG_FAN_SEL,
	input  wire logic [MCFG_W-1:0] CFG_MOTOR_CFG,
	input  wire logic              CFG_MOTOR_OUT_EN,
	output logic                   CORE_RAIL_EN,
	output logic                   RAIL_3V3_EN,
	output logic                   RAIL_2V5_EN,
	output logic                   LINEAR_RAIL_A_EN,
	output logic                   LINEAR_RAIL_B_EN,
	output logic                   RAIL_5V_EN,
	output logic                   MOTOR_SUPPLY_RAIL_EN,
	output logic                   SOFT_START,
	output logic                   RAILS_SENSED_OK,
	output logic                   SUPPLY_GOOD_FLAG,
	output logic                   THERMAL_WARNING,
	output logic                   THERMAL_SHUTDOWN,
	output logic                   INT_REQ,
	output logic [NUM_FANS-1:0]    FAN_EN,
	output logic [NUM_FANS*PWM_W-1:0] FAN_PWM,
	output logic [MCFG_W-1:0]      MOTOR_CFG,
	output logic                   MOTOR_OUT_EN
);
	localparam int unsigned NS = 10;

	logic [NS-1:0] pins;
	logic [NS-1:0] s;

	assign pins = {INPUT_ABOVE_SHUTDOWN, INPUT_ABOVE_WARN,
		CORE_ABOVE_UVLO, RAIL_3V3_ABOVE_UVLO, RAIL_2V5_ABOVE_UVLO,
		CHARGE_PUMP_OK, INTERNAL_REG_OK, TEMP_ABOVE_WARN,
		TEMP_ABOVE_SHUTDOWN, ~SYSTEM_RESET_N};
	// reset request carried inverted so the synced idle level is no reset

	rsq_sync #(
		.W (NS)
	) u_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (pins),
		.q     (s)
	);

	logic in_sd;
	logic in_warn;
	logic core_ok;
	logic r33_ok;
	logic r25_ok;
	logic cp_ok;
	logic ireg_ok;
	logic t_warn;
	logic t_sd;
	logic sysrst_n;

	assign in_sd    = s[9];
	assign in_warn  = s[8];
	assign core_ok  = s[7];
	assign r33_ok   = s[6];
	assign r25_ok   = s[5];
	assign cp_ok    = s[4];
	assign ireg_ok  = s[3];
	assign t_warn   = s[2];
	assign t_sd     = s[1];
	assign sysrst_n = !s[0];

	typedef struct packed {
		rsq_state_e                 st;
		logic [CNT_W-1:0]           ss_cnt;
		logic [CNT_W-1:0]           por_cnt;
		logic                       core_en;
		logic                       main_en;
		logic                       sec_en;
		logic                       soft_start;
		logic                       sensed_ok;
		logic                       good;
		logic                       thermal_warning;
		logic                       tsd;
		logic                       int_req;
		logic                       lin_a_cfg;
		logic                       lin_b_cfg;
		logic                       v5_cfg;
		logic                       mot_cfg_en;
		logic                       lin_a_en;
		logic                       lin_b_en;
		logic                       v5_en;
		logic                       mot_en;
		logic [NUM_FANS-1:0]        fan_en;
		logic [NUM_FANS*PWM_W-1:0]  fan_pwm;
		logic [MCFG_W-1:0]          mcfg;
		logic                       mout_en;
	} rsq_regs_s;

	rsq_regs_s cur_r;
	rsq_regs_s cur_nxt;

	logic three_ok;
	logic fault;

	assign three_ok = core_ok && r33_ok && r25_ok;
	// any condition that forces all channels off
	assign fault = !in_sd || !cp_ok || !ireg_ok || t_sd;

	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.thermal_warning = t_warn;
		cur_nxt.tsd   = t_sd;
		cur_nxt.int_req = t_warn && THERMAL_WARNING_IRQ_EN;

		// software writes of settings
		if (CFG_WR) begin
			cur_nxt.lin_a_cfg  = CFG_LIN_A_EN;
			cur_nxt.lin_b_cfg  = CFG_LIN_B_EN;
			cur_nxt.v5_cfg     = CFG_5V_EN;
			cur_nxt.mot_cfg_en = CFG_MOTOR_RAIL_EN;
			cur_nxt.fan_en     = CFG_FAN_EN;
			cur_nxt.mcfg       = CFG_MOTOR_CFG;
			cur_nxt.mout_en    = CFG_MOTOR_OUT_EN;
			for (int i = 0; i < NUM_FANS; i++) begin
				if (CFG_FAN_SEL == 2'(i)) begin
					cur_nxt.fan_pwm[i*PWM_W +: PWM_W] = CFG_FAN_PWM;
				end
			end
		end

		// masked system reset wins over a write in the same cycle
		if (!sysrst_n) begin
			if (!FAN_RESET_MASK) begin
				cur_nxt.fan_en  = '0;
				cur_nxt.fan_pwm = {NUM_FANS{PWM_RST}};
			end
			if (!REGULATOR_RESET_MASK) begin
				cur_nxt.lin_a_cfg = 1'b1;
				cur_nxt.lin_b_cfg = 1'b1;
				cur_nxt.v5_cfg    = 1'b1;
			end
			if (!MOTOR_CFG_RESET_MASK) begin
				cur_nxt.mcfg = MCFG_RST;
			end
			if (!MOTOR_OUT_EN_RESET_MASK) begin
				cur_nxt.mout_en = 1'b0;
			end
		end

		unique case (cur_r.st)
			ST_OFF: begin
				if (!fault) begin
					cur_nxt.st      = ST_CORE_SS;
					cur_nxt.ss_cnt  = '0;
					cur_nxt.core_en = 1'b1;
					cur_nxt.soft_start = 1'b1;
				end
			end
			ST_CORE_SS: begin
				if (cur_r.ss_cnt < CNT_W'(SS_CNT - 1)) begin
					cur_nxt.ss_cnt = cur_r.ss_cnt + 1'b1;
				end else if (core_ok) begin
					cur_nxt.st      = ST_MAIN_SS;
					cur_nxt.main_en = 1'b1;
				end
			end
			ST_MAIN_SS: begin
				if (three_ok) begin
					cur_nxt.st      = ST_RUN;
					cur_nxt.sec_en  = 1'b1;
					cur_nxt.por_cnt = '0;
					cur_nxt.soft_start = 1'b0;
				end
			end
			ST_RUN: begin
				if (!three_ok) begin
					cur_nxt.por_cnt = '0;
				end else if (cur_r.por_cnt < CNT_W'(POR_CNT)) begin
					cur_nxt.por_cnt = cur_r.por_cnt + 1'b1;
				end
			end
			default: begin
				cur_nxt.st = ST_OFF;
			end
		endcase

		if (fault) begin
			cur_nxt.st         = ST_OFF;
			cur_nxt.core_en    = 1'b0;
			cur_nxt.main_en    = 1'b0;
			cur_nxt.sec_en     = 1'b0;
			cur_nxt.soft_start = 1'b0;
			cur_nxt.ss_cnt     = '0;
			cur_nxt.por_cnt    = '0;
		end

		// 5v gates the linear rails
		cur_nxt.v5_en    = cur_nxt.sec_en && cur_nxt.v5_cfg;
		cur_nxt.lin_a_en = cur_nxt.v5_en && cur_nxt.lin_a_cfg;
		cur_nxt.lin_b_en = cur_nxt.v5_en && cur_nxt.lin_b_cfg;
		cur_nxt.mot_en   = cur_nxt.sec_en && cur_nxt.mot_cfg_en;

		cur_nxt.sensed_ok = (cur_nxt.st == ST_RUN) && three_ok
			&& (cur_nxt.por_cnt >= CNT_W'(POR_CNT));
		cur_nxt.good = cur_nxt.sensed_ok && in_warn;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cur_r            <= '0;
			cur_r.st         <= ST_OFF;
			cur_r.lin_a_cfg  <= 1'b1;
			cur_r.lin_b_cfg  <= 1'b1;
			cur_r.v5_cfg     <= 1'b1;
			cur_r.mot_cfg_en <= 1'b1;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign CORE_RAIL_EN         = cur_r.core_en;
	assign RAIL_3V3_EN          = cur_r.main_en;
	assign RAIL_2V5_EN          = cur_r.main_en;
	assign LINEAR_RAIL_A_EN     = cur_r.lin_a_en;
	assign LINEAR_RAIL_B_EN     = cur_r.lin_b_en;
	assign RAIL_5V_EN           = cur_r.v5_en;
	assign MOTOR_SUPPLY_RAIL_EN = cur_r.mot_en;
	assign SOFT_START           = cur_r.soft_start;
	assign RAILS_SENSED_OK      = cur_r.sensed_ok;
	assign SUPPLY_GOOD_FLAG     = cur_r.good;
	assign THERMAL_WARNING      = cur_r.thermal_warning;
	assign THERMAL_SHUTDOWN     = cur_r.tsd;
	assign INT_REQ              = cur_r.int_req;
	assign FAN_EN               = cur_r.fan_en;
	assign FAN_PWM              = cur_r.fan_pwm;
	assign MOTOR_CFG            = cur_r.mcfg;
	assign MOTOR_OUT_EN         = cur_r.mout_en;
endmodule
`default_nettype wire

// File: dv/rsq_checker.sv
// port assertions for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module rsq_checker #(
	parameter int unsigned SS_CNT = 20
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic INPUT_ABOVE_SHUTDOWN,
	input wire logic CORE_ABOVE_UVLO,
	input wire logic TEMP_ABOVE_WARN,
	input wire logic TEMP_ABOVE_SHUTDOWN,
	input wire logic CORE_RAIL_EN,
	input wire logic RAIL_3V3_EN,
	input wire logic LINEAR_RAIL_A_EN,
	input wire logic RAIL_5V_EN,
	input wire logic RAILS_SENSED_OK,
	input wire logic SUPPLY_GOOD_FLAG,
	input wire logic THERMAL_WARNING,
	input wire logic INT_REQ
);
	logic [31:0] on_cnt_r;
	// cycles the core rail has been enabled
	always_ff @(posedge CLK_SYS or negedge RST_N)
		if (!RST_N)
			on_cnt_r <= '0;
		else if (!CORE_RAIL_EN)
			on_cnt_r <= '0;
		else
			on_cnt_r <= on_cnt_r + 32'h0000_0001;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_core_low; !CORE_ABOVE_UVLO[*3]; endsequence
	sequence s_in_low; !INPUT_ABOVE_SHUTDOWN[*3]; endsequence
	sequence s_hot; TEMP_ABOVE_SHUTDOWN[*3]; endsequence
	sequence s_warm; TEMP_ABOVE_WARN[*3]; endsequence
	property p_good; SUPPLY_GOOD_FLAG |-> RAILS_SENSED_OK; endproperty
	a_good: assert property (p_good) else $error("good without sensed");
	property p_lin; LINEAR_RAIL_A_EN |-> RAIL_5V_EN; endproperty
	a_lin: assert property (p_lin) else $error("linear without 5v");
	property p_irq; INT_REQ |-> THERMAL_WARNING; endproperty
	a_irq: assert property (p_irq) else $error("irq without warning");
	property p_core; s_core_low |=> !RAILS_SENSED_OK && !SUPPLY_GOOD_FLAG;
	endproperty
	a_core: assert property (p_core) else $error("flags stay up");
	property p_uvsd; s_in_low |=> !CORE_RAIL_EN && !RAIL_3V3_EN; endproperty
	a_uvsd: assert property (p_uvsd) else $error("rails on at uv");
	property p_tsd; s_hot |=> !CORE_RAIL_EN && !RAIL_5V_EN; endproperty
	a_tsd: assert property (p_tsd) else $error("rails on when hot");
	property p_warn; s_warm |=> THERMAL_WARNING; endproperty
	a_warn: assert property (p_warn) else $error("no thermal warning");
	property p_ss; $rose(RAIL_3V3_EN) |-> on_cnt_r >= SS_CNT - 1; endproperty
	a_ss: assert property (p_ss) else $error("3v3 before soft start");
endmodule
bind rsq_top rsq_checker #(.SS_CNT(SS_CNT)) u_chk (.*);
`default_nettype wire

// File: dv/rsq_ctrl_model.sv
// display controller model: system reset and config writes
`timescale 1ns/1ps
`default_nettype none
module rsq_ctrl_model (
	input  wire logic        clk,
	output logic        rst_n,
	output logic        wr,
	output logic [33:0] cfg
);
	initial begin
		rst_n = 1'b1;
		wr = 1'b0;
		cfg = '1;
	end
	task automatic write(input logic [33:0] v);
		@(posedge clk);
		#1;
		cfg = v;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		cfg = ~v;
	endtask
	task automatic pulse_rst(input int n);
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// testbench for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rsq_pkg::*;
	localparam int SS = 20;
	localparam int POR = 50;
	logic CLK_SYS = 0, RST_N = 0, INPUT_ABOVE_WARN = 0;
	logic TEMP_ABOVE_WARN = 0, THERMAL_WARNING_IRQ_EN = 0;
	logic [3:0] flt = 4'hF, msk = 4'h0;
	logic [2:0] uv = 3'h0, fe = 3'h0, rg = 3'h7;
	logic [23:0] pw = '0;
	logic [15:0] mc = '0;
	logic moe = 0, mr = 1;
	logic [33:0] cfg;
	logic [31:0] rnd = 32'h0000_7115;
	int error_cnt = 0, samples_checked = 0, cyc_n = 0;
	wire INPUT_ABOVE_SHUTDOWN, CHARGE_PUMP_OK, INTERNAL_REG_OK;
	wire TEMP_ABOVE_SHUTDOWN, CORE_ABOVE_UVLO, RAIL_3V3_ABOVE_UVLO;
	wire RAIL_2V5_ABOVE_UVLO, SYSTEM_RESET_N, CFG_WR, FAN_RESET_MASK;
	wire REGULATOR_RESET_MASK, MOTOR_CFG_RESET_MASK, MOTOR_OUT_EN_RESET_MASK;
	wire CFG_LIN_A_EN, CFG_LIN_B_EN, CFG_5V_EN, CFG_MOTOR_RAIL_EN;
	wire CFG_MOTOR_OUT_EN;
	wire [NUM_FANS-1:0] CFG_FAN_EN;
	wire [PWM_W-1:0] CFG_FAN_PWM;
	wire [1:0] CFG_FAN_SEL;
	wire [MCFG_W-1:0] CFG_MOTOR_CFG;
	logic CORE_RAIL_EN, RAIL_3V3_EN, RAIL_2V5_EN, LINEAR_RAIL_A_EN;
	logic LINEAR_RAIL_B_EN, RAIL_5V_EN, MOTOR_SUPPLY_RAIL_EN, SOFT_START;
	logic RAILS_SENSED_OK, SUPPLY_GOOD_FLAG, THERMAL_WARNING, INT_REQ;
	logic THERMAL_SHUTDOWN, MOTOR_OUT_EN;
	logic [NUM_FANS-1:0] FAN_EN;
	logic [NUM_FANS*PWM_W-1:0] FAN_PWM;
	logic [MCFG_W-1:0] MOTOR_CFG;
	assign {INTERNAL_REG_OK, CHARGE_PUMP_OK, INPUT_ABOVE_SHUTDOWN} = ~flt[2:0];
	assign TEMP_ABOVE_SHUTDOWN = flt[3];
	assign {RAIL_2V5_ABOVE_UVLO, RAIL_3V3_ABOVE_UVLO, CORE_ABOVE_UVLO} = uv;
	assign {MOTOR_OUT_EN_RESET_MASK, MOTOR_CFG_RESET_MASK,
		REGULATOR_RESET_MASK, FAN_RESET_MASK} = msk;
	assign {CFG_LIN_A_EN, CFG_LIN_B_EN, CFG_5V_EN, CFG_MOTOR_RAIL_EN, CFG_FAN_EN,
		CFG_FAN_PWM, CFG_FAN_SEL, CFG_MOTOR_CFG, CFG_MOTOR_OUT_EN} = cfg;
	rsq_top #(.SS_CNT(SS), .POR_CNT(POR)) uut (.*);
	rsq_ctrl_model u_ctl (.clk(CLK_SYS), .rst_n(SYSTEM_RESET_N), .wr(CFG_WR),
		.cfg(cfg));
	always #2 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) if (++cyc_n > 5000) begin
		error_cnt++;
		finish_test();
	end
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic void exp_write(logic [33:0] v);
		logic [7:0] p;
		logic [1:0] s;
		{rg, mr, fe, p, s, mc, moe} = v;
		if (s != 2'h3) pw[s*8 +: 8] = p;
	endfunction
	function automatic void exp_reset();
		if (!msk[0]) {fe, pw} = '0;
		if (!msk[1]) rg = 3'h7;
		if (!msk[2]) mc = '0;
		if (!msk[3]) moe = 1'b0;
	endfunction
	task automatic finish_test;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic cmp_cfg;
		cyc(2);
		chk("fan_en", fe, FAN_EN);
		chk("pwm", pw, FAN_PWM);
		chk("mcfg", mc, MOTOR_CFG);
		chk("moe", moe, MOTOR_OUT_EN);
		chk("rails", {rg[0], rg[2] & rg[0], rg[1] & rg[0], mr},
			{RAIL_5V_EN, LINEAR_RAIL_A_EN, LINEAR_RAIL_B_EN, MOTOR_SUPPLY_RAIL_EN});
	endtask
	task automatic rampup;
		for (int i = 0; i < 20 && CORE_RAIL_EN !== 1'b1; i++) cyc(1);
		chk("soft", 2'h3, {CORE_RAIL_EN, SOFT_START});
		uv = 3'h1;
		cyc(SS - 4);
		chk("en3v3", 0, RAIL_3V3_EN);
		cyc(10);
		chk("en3v3", 1, RAIL_3V3_EN & RAIL_2V5_EN);
		uv = 3'h7;
		cyc(5);
		chk("en5v", 1, RAIL_5V_EN & MOTOR_SUPPLY_RAIL_EN);
		cyc(POR - 8);
		chk("sensed", 0, RAILS_SENSED_OK);
		cyc(10);
		chk("sensed", 2'h3, {RAILS_SENSED_OK, SUPPLY_GOOD_FLAG});
	endtask
	initial begin
		cyc(4);
		RST_N = 1'b1;
		flt = 4'h0;
		INPUT_ABOVE_WARN = 1'b1;
		rampup();
		cmp_cfg();
		INPUT_ABOVE_WARN = 1'b0;
		TEMP_ABOVE_WARN = 1'b1;
		cyc(4);
		chk("good", 2'h1, {SUPPLY_GOOD_FLAG, CORE_RAIL_EN});
		chk("thermal_warning", 2'h2, {THERMAL_WARNING, INT_REQ});
		INPUT_ABOVE_WARN = 1'b1;
		THERMAL_WARNING_IRQ_EN = 1'b1;
		cyc(4);
		chk("irq", 2'h3, {INT_REQ, SUPPLY_GOOD_FLAG});
		for (int k = 0; k < 3; k++) begin
			uv[k] = 1'b0;
			cyc(4);
			chk("drop", 1, {RAILS_SENSED_OK, SUPPLY_GOOD_FLAG, CORE_RAIL_EN});
			uv[k] = 1'b1;
			cyc(POR + 8);
			chk("sensed", 1, RAILS_SENSED_OK);
		end
		for (int k = 0; k < 4; k++) begin
			flt[k] = 1'b1;
			cyc(4);
			chk("off", 0, {CORE_RAIL_EN, RAIL_3V3_EN, RAIL_5V_EN});
			chk("tsd", k == 3, THERMAL_SHUTDOWN);
			uv = 3'h0;
			flt[k] = 1'b0;
			rampup();
		end
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			u_ctl.write({rnd, rnd[3:2]});
			exp_write({rnd, rnd[3:2]});
			cmp_cfg();
			rnd = lfsr(rnd);
			msk = i == 0 ? 4'hF : i == 1 ? 4'h0 : rnd[3:0];
			u_ctl.pulse_rst(3);
			exp_reset();
			cyc(6);
			cmp_cfg();
		end
		finish_test();
	end
endmodule
`default_nettype wire
